// File: hw/oad_cycles.sv
`default_nettype none
`include "oad_defs.svh"
// Instruction cycle-count table; registered output
module oad_cycles (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Query
    input wire logic [7:0] opcode,
    input wire logic taken,
    input wire logic [7:0] level,
    input wire logic word_op,
    input wire logic [1:0] mem_xfers,
    // Answer
    output logic [7:0] cycles_q,
    output logic known_q
);
    logic [7:0] base_d;
    logic known_d;
    logic [7:0] word_add;
    // Table lookup
    always_comb begin
        base_d = `OAD_ZERO8;
        known_d = 1'b1;
        unique case (opcode)
            `OAD_OP_LOOP_ZERO, `OAD_OP_LOOP_NZERO: begin
                base_d = taken ? `OAD_LOOP_T : `OAD_LOOP_NT; // [RULE15]
            end
            `OAD_OP_FRAME: begin
                // Level above one grows by a fixed step; 8-bit count wraps past level 12
                if (level == 8'h00) base_d = `OAD_FRAME_L0; // [RULE16]
                else if (level == 8'h01) base_d = `OAD_FRAME_L1; // [RULE16]
                else base_d = 8'(`OAD_FRAME_LN + `OAD_FRAME_PER * (level - 8'h01)); // [RULE16]
            end
            `OAD_OP_OVTRAP: begin
                base_d = taken ? `OAD_TRAP_T : `OAD_TRAP_NT; // [RULE17]
            end
            `OAD_OP_RANGE: begin
                // Worst case reported; the true figure varies within the range
                base_d = `OAD_RANGE_MAX; // [RULE18]
            end
            `OAD_OP_BUSHOLD: begin
                base_d = `OAD_HOLD_CYC; // [RULE19]
            end
            default: begin
                known_d = 1'b0;
            end
        endcase
    end
    // Word penalty per memory transfer
    assign word_add = word_op ? 8'(`OAD_WORD_ADD * mem_xfers) : `OAD_ZERO8; // [RULE20]
    // Result register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cycles_q <= `OAD_ZERO8;
            known_q <= 1'b0;
        end else begin
            cycles_q <= 8'(base_d + word_add);
            known_q <= known_d;
        end
    end
    range_bounds_a: assert property (@(posedge clk) disable iff (!rst_n)
        known_q && $past(opcode) == `OAD_OP_RANGE && !$past(word_op)
        |-> cycles_q >= `OAD_RANGE_MIN && cycles_q <= `OAD_RANGE_MAX) // [RULE18]
        else $error("range check cycles out of bounds");
endmodule // oad_cycles
`default_nettype wire

// File: hw/oad_decode.sv
// Contract
// RULE1 - Form 11 selects a register operand
// RULE2 - Form 00 means zero displacement
// RULE3 - Form 00 select 110: direct 16-bit address
// RULE4 - Form 01: one byte, sign-extended
// RULE5 - Form 10: two bytes, low first
// RULE6 - Selects 000, 010, 011 address sums
// RULE7 - Select 111 is base index plus displacement
// RULE8 - Selects 001, 100, 101, 110 customary sums
// RULE9 - Displacement follows second instruction byte
// RULE10 - Address calculation costs four cycles
// RULE11 - Override prefix maps segment codes
// RULE12 - Register field picks word or byte register
// RULE13 - Frame base addresses default to stack
// RULE14 - String destination always uses extra segment
// RULE15 - Conditional loops take 6 or 16
// RULE16 - Frame setup 19, 29, 26 plus 20n
// RULE17 - Overflow trap 48 taken, 4 not
// RULE18 - Range check 33 to 35 cycles
// RULE19 - Bus-hold prefix recognised, 2 cycles
// RULE20 - Word operations add 4 per transfer
`default_nettype none
`include "oad_defs.svh"
module oad_decode (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Instruction byte stream
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic first_byte,
    // Operation context
    input wire logic word_op,
    input wire logic string_dst,
    input wire oad_pkg::oad_regs_type regs,
    // Cycle query
    input wire logic taken,
    input wire logic [7:0] level,
    input wire logic [1:0] mem_xfers,
    // Decoded operand
    output oad_pkg::oad_result_type result_q,
    output logic prefix_q,
    output logic bushold_q,
    output logic [7:0] ea_cycles_q,
    output logic [7:0] op_cycles_q,
    output logic op_known_q
);
    oad_pkg::oad_dec_type s_q, s_d;
    logic [7:0] opcode_q;
    logic pfx_q, pfx_d;
    logic hold_q, hold_d;
    logic [7:0] eac_q, eac_d;

    // Segment override prefix detector, used only by the idle state
    function automatic logic is_seg_pfx(input logic [7:0] b);
        return b[7:5] == `OAD_PFX_HI && b[2:0] == `OAD_PFX_LO; // [RULE11]
    endfunction

    // Base plus index sum per operand-select code
    function automatic logic [15:0] base_sum(input logic [2:0] sel,
                                             input oad_pkg::oad_regs_type r);
        logic [15:0] v;
        v = `OAD_ZERO16;
        unique case (sel)
            `OAD_SEL_BASE_SRC: v = 16'(r.base_index_register + r.source_index); // [RULE6]
            `OAD_SEL_BASE_DST: v = 16'(r.base_index_register + r.destination_index); // [RULE8]
            `OAD_SEL_FRAME_SRC: v = 16'(r.frame_base_register + r.source_index); // [RULE6]
            `OAD_SEL_FRAME_DST: v = 16'(r.frame_base_register + r.destination_index); // [RULE6]
            `OAD_SEL_SRC: v = r.source_index; // [RULE8]
            `OAD_SEL_DST: v = r.destination_index; // [RULE8]
            `OAD_SEL_FRAME: v = r.frame_base_register; // [RULE8]
            `OAD_SEL_BASE: v = r.base_index_register; // [RULE7]
        endcase
        return v;
    endfunction

    // Default segment: frame base forms use stack, others data
    function automatic logic [1:0] dflt_seg(input logic [2:0] sel);
        logic uses_frame;
        uses_frame = sel == `OAD_SEL_FRAME_SRC || sel == `OAD_SEL_FRAME_DST
            || sel == `OAD_SEL_FRAME;
        return uses_frame ? `OAD_SEG_STACK : `OAD_SEG_DATA; // [RULE13]
    endfunction

    // Sequencer next state
    always_comb begin
        logic direct;
        logic [15:0] ea;
        logic [1:0] seg;
        direct = 1'b0;
        ea = `OAD_ZERO16;
        seg = `OAD_SEG_DATA;
        s_d = s_q;
        s_d.res.valid = 1'b0;
        pfx_d = 1'b0;
        hold_d = 1'b0;
        eac_d = eac_q;
        unique case (s_q.st)
            oad_pkg::OAD_IDLE: begin
                // Prefixes accumulate; the opcode byte moves on to the addressing byte
                if (byte_valid && first_byte) begin
                    if (is_seg_pfx(byte_data)) begin
                        s_d.seg_ovr = 1'b1;
                        s_d.seg_code = byte_data[4:3]; // [RULE11]
                        pfx_d = 1'b1;
                    end else if (byte_data == `OAD_OP_BUSHOLD) begin
                        pfx_d = 1'b1; // [RULE19]
                        hold_d = 1'b1; // [RULE19]
                    end else begin
                        s_d.wbit = word_op;
                        s_d.string_dst = string_dst;
                        s_d.st = oad_pkg::OAD_MODRM;
                    end
                end
            end
            oad_pkg::OAD_MODRM: begin
                // Second byte; displacement bytes come right after it
                if (byte_valid) begin
                    s_d.form = byte_data[7:6];
                    s_d.sel = byte_data[2:0];
                    s_d.disp = `OAD_ZERO16; // [RULE2]
                    direct = byte_data[7:6] == `OAD_FORM_NODISP
                        && byte_data[2:0] == `OAD_SEL_FRAME;
                    if (byte_data[7:6] == `OAD_FORM_DISP8
                        || byte_data[7:6] == `OAD_FORM_DISP16 || direct)
                        s_d.st = oad_pkg::OAD_DLO; // [RULE9]
                    else
                        s_d.st = oad_pkg::OAD_DONE; // [RULE2]
                end
            end
            oad_pkg::OAD_DLO: begin
                if (byte_valid) begin
                    s_d.dlo = byte_data;
                    if (s_q.form == `OAD_FORM_DISP8) begin
                        s_d.disp = {{8{byte_data[7]}}, byte_data}; // [RULE4]
                        s_d.st = oad_pkg::OAD_DONE;
                    end else begin
                        s_d.st = oad_pkg::OAD_DHI; // [RULE5]
                    end
                end
            end
            oad_pkg::OAD_DHI: begin
                if (byte_valid) begin
                    s_d.disp = {byte_data, s_q.dlo}; // [RULE3] [RULE5]
                    s_d.st = oad_pkg::OAD_DONE;
                end
            end
            oad_pkg::OAD_DONE: begin
                // Resolve address and segment, publish one-cycle result
                direct = s_q.form == `OAD_FORM_NODISP && s_q.sel == `OAD_SEL_FRAME;
                ea = direct ? s_q.disp : 16'(base_sum(s_q.sel, regs) + s_q.disp); // [RULE3]
                seg = direct ? `OAD_SEG_DATA : dflt_seg(s_q.sel); // [RULE13]
                if (s_q.seg_ovr) seg = s_q.seg_code; // [RULE11]
                // Override cannot move a string destination
                if (s_q.string_dst) seg = `OAD_SEG_EXTRA; // [RULE14]
                s_d.res.is_reg = s_q.form == `OAD_FORM_REG; // [RULE1]
                s_d.res.reg_num = {s_q.wbit, s_q.sel}; // [RULE12]
                s_d.res.effective_address = s_q.form == `OAD_FORM_REG ? `OAD_ZERO16 : ea;
                s_d.res.segment = seg;
                s_d.res.valid = 1'b1;
                eac_d = s_q.form == `OAD_FORM_REG ? `OAD_ZERO8 : `OAD_EA_CYC; // [RULE10]
                s_d.seg_ovr = 1'b0;
                s_d.st = oad_pkg::OAD_IDLE;
            end
            default: begin
                s_d.st = oad_pkg::OAD_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            opcode_q <= `OAD_ZERO8;
            pfx_q <= 1'b0;
            hold_q <= 1'b0;
            eac_q <= `OAD_ZERO8;
        end else begin
            s_q <= s_d;
            pfx_q <= pfx_d;
            hold_q <= hold_d;
            eac_q <= eac_d;
            if (byte_valid && first_byte) opcode_q <= byte_data;
        end
    end

    // Cycle table for the latest opcode
    oad_cycles u_cycles (
        .clk(clk),
        .rst_n(rst_n),
        .opcode(opcode_q),
        .taken(taken),
        .level(level),
        .word_op(word_op),
        .mem_xfers(mem_xfers),
        .cycles_q(op_cycles_q),
        .known_q(op_known_q)
    );

    assign result_q = s_q.res;
    assign prefix_q = pfx_q;
    assign bushold_q = hold_q;
    assign ea_cycles_q = eac_q;

    // Checks
    reg_form_a: assert property (@(posedge clk) disable iff (!rst_n)
        result_q.valid && result_q.is_reg |-> result_q.effective_address == 16'h0000) // [RULE1]
        else $error("register form gave an address");
    nodisp_done_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.st == oad_pkg::OAD_MODRM && byte_valid && byte_data[7:6] == 2'b00
        && byte_data[2:0] != 3'b110 |=> s_q.st == oad_pkg::OAD_DONE) // [RULE2]
        else $error("form 00 fetched displacement");
    direct_ea_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.st == oad_pkg::OAD_DONE && s_q.form == 2'b00 && s_q.sel == 3'b110
        |=> result_q.effective_address == $past(s_q.disp)) // [RULE3]
        else $error("direct address not taken from displacement");
    sign_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.st == oad_pkg::OAD_DLO && s_q.form == 2'b01 && byte_valid
        |=> s_q.disp[15:8] == {8{s_q.disp[7]}} && s_q.st == oad_pkg::OAD_DONE) // [RULE4]
        else $error("short displacement not sign-extended");
    ea_cost_a: assert property (@(posedge clk) disable iff (!rst_n)
        result_q.valid && !result_q.is_reg |-> ea_cycles_q == 8'h04) // [RULE10]
        else $error("address cost not four cycles");
    string_seg_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.st == oad_pkg::OAD_DONE && s_q.string_dst |=> result_q.segment == 2'b00) // [RULE14]
        else $error("string destination left extra segment");
    stack_seg_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.st == oad_pkg::OAD_DONE && !s_q.seg_ovr && !s_q.string_dst
        && s_q.form != 2'b00 && s_q.sel == 3'b110 |=> result_q.segment == 2'b10) // [RULE13]
        else $error("frame base not on stack segment");
    hold_pfx_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_q.st == oad_pkg::OAD_IDLE && byte_valid && first_byte && byte_data == 8'hF0
        |=> prefix_q && bushold_q ##1 op_cycles_q == 8'h02) // [RULE19]
        else $error("bus-hold prefix not recognised");
endmodule // oad_decode
`default_nettype wire

// File: shared/oad_defs.svh
`ifndef OAD_DEFS_SVH
`define OAD_DEFS_SVH
// Addressing-form codes
`define OAD_FORM_NODISP 2'b00
`define OAD_FORM_DISP8 2'b01
`define OAD_FORM_DISP16 2'b10
`define OAD_FORM_REG 2'b11
// Operand-select codes
`define OAD_SEL_BASE_SRC 3'b000
`define OAD_SEL_BASE_DST 3'b001
`define OAD_SEL_FRAME_SRC 3'b010
`define OAD_SEL_FRAME_DST 3'b011
`define OAD_SEL_SRC 3'b100
`define OAD_SEL_DST 3'b101
`define OAD_SEL_FRAME 3'b110
`define OAD_SEL_BASE 3'b111
// Segment codes and prefix pattern
`define OAD_SEG_EXTRA 2'b00
`define OAD_SEG_CODE 2'b01
`define OAD_SEG_STACK 2'b10
`define OAD_SEG_DATA 2'b11
`define OAD_PFX_HI 3'b001
`define OAD_PFX_LO 3'b110
// Opcodes
`define OAD_OP_LOOP_ZERO 8'hE1
`define OAD_OP_LOOP_NZERO 8'hE0
`define OAD_OP_FRAME 8'hC8
`define OAD_OP_OVTRAP 8'hCE
`define OAD_OP_RANGE 8'h62
`define OAD_OP_BUSHOLD 8'hF0
// Cycle counts
`define OAD_EA_CYC 8'h04
`define OAD_LOOP_NT 8'h06
`define OAD_LOOP_T 8'h10
`define OAD_FRAME_L0 8'h13
`define OAD_FRAME_L1 8'h1D
`define OAD_FRAME_LN 8'h1A
`define OAD_FRAME_PER 8'h14
`define OAD_TRAP_T 8'h30
`define OAD_TRAP_NT 8'h04
`define OAD_RANGE_MIN 8'h21
`define OAD_RANGE_MAX 8'h23
`define OAD_HOLD_CYC 8'h02
`define OAD_WORD_ADD 8'h04
`define OAD_ZERO16 16'h0000
`define OAD_ZERO8 8'h00
`endif

// File: shared/oad_pkg.sv
`default_nettype none
package oad_pkg;
    // Decoder sequencer states
    typedef enum logic [2:0] {
        OAD_IDLE = 3'b000,
        OAD_MODRM = 3'b001,
        OAD_DLO = 3'b010,
        OAD_DHI = 3'b011,
        OAD_DONE = 3'b100
    } oad_state_type;
    // Base register file snapshot from the execution unit
    typedef struct packed {
        logic [15:0] base_index_register;
        logic [15:0] frame_base_register;
        logic [15:0] source_index;
        logic [15:0] destination_index;
    } oad_regs_type;
    // Decoded operand result
    typedef struct packed {
        logic [15:0] effective_address;
        logic [1:0] segment;
        logic is_reg;
        logic [3:0] reg_num;
        logic valid;
    } oad_result_type;
    // Whole decoder state
    typedef struct packed {
        oad_state_type st;
        logic [1:0] form;
        logic [2:0] sel;
        logic [7:0] dlo;
        logic [15:0] disp;
        logic seg_ovr;
        logic [1:0] seg_code;
        logic wbit;
        logic string_dst;
        oad_result_type res;
    } oad_dec_type;
endpackage : oad_pkg
`default_nettype wire

// File: verif/oad_core_model.sv
`default_nettype none
// Execution-side model: feeds instruction bytes and holds the live register file
module oad_core_model (
    // Clock
    input wire logic clk,
    // Instruction byte stream
    output var logic byte_valid,
    output var logic [7:0] byte_data,
    output var logic first_byte,
    // Register file snapshot
    output var oad_pkg::oad_regs_type regs
);
    timeunit 1ns;
    timeprecision 1ps;

    // Distinct register values so that a wrong base register shows in the sum
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
        first_byte = 1'b0;
        regs = {16'h1000, 16'h2000, 16'h0300, 16'h0040};
    end

    // One byte per call, held until the taking edge; the released bus shows
    // the inverse of the last byte so that a stale value never passes
    task automatic send(input logic [7:0] b, input logic f);
        @(posedge clk);
        byte_valid <= 1'b1;
        byte_data <= b;
        first_byte <= f;
        @(posedge clk);
        byte_valid <= 1'b0;
        byte_data <= ~b;
        first_byte <= ~f;
    endtask
endmodule // oad_core_model
`default_nettype wire

// File: verif/testbench.sv
`default_nettype none
// Compare and count; an unknown never matches
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // One entry of the cycle-count table
    typedef struct packed {
        logic [7:0] opc;
        logic tk;
        logic [7:0] lv;
        logic wd;
        logic [1:0] nx;
        logic [7:0] cyc;
    } oad_cyc_case_type;

    // Clock, reset and context inputs
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic word_op = 1'b0;
    logic string_dst = 1'b0;
    logic taken = 1'b0;
    logic [7:0] level = 8'h00;
    logic [1:0] mem_xfers = 2'b00;
    // Partner-driven stream
    logic byte_valid;
    logic [7:0] byte_data;
    logic first_byte;
    oad_pkg::oad_regs_type regs;
    // Design outputs
    oad_pkg::oad_result_type result_q;
    logic prefix_q;
    logic bushold_q;
    logic [7:0] ea_cycles_q;
    logic [7:0] op_cycles_q;
    logic op_known_q;
    int error_cnt = 0;
    int n_compared = 0;

    always #5 clk = ~clk;

    oad_core_model oad_core_model_inst (.clk(clk), .byte_valid(byte_valid),
        .byte_data(byte_data), .first_byte(first_byte), .regs(regs));

    oad_decode oad_decode_inst (.clk(clk), .rst_n(rst_n), .byte_valid(byte_valid),
        .byte_data(byte_data), .first_byte(first_byte), .word_op(word_op),
        .string_dst(string_dst), .regs(regs), .taken(taken), .level(level),
        .mem_xfers(mem_xfers), .result_q(result_q), .prefix_q(prefix_q),
        .bushold_q(bushold_q), .ea_cycles_q(ea_cycles_q), .op_cycles_q(op_cycles_q),
        .op_known_q(op_known_q));

    // Verdict and end of run
    task automatic conclude();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Bounded wait for the result pulse
    task automatic wait_res();
        for (int i = 0; i < 8 && result_q.valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (result_q.valid !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t no result", $time);
            conclude();
        end
    endtask

    // Opcode, addressing byte and n displacement bytes, low first
    task automatic op(input logic [7:0] m, input logic [7:0] d0, input logic [7:0] d1,
                      input int n);
        oad_core_model_inst.send(8'h8B, 1'b1);
        oad_core_model_inst.send(m, 1'b0);
        if (n > 0) begin
            oad_core_model_inst.send(d0, 1'b0);
        end
        if (n > 1) begin
            oad_core_model_inst.send(d1, 1'b0);
        end
        wait_res();
    endtask

    // Every select code without displacement, except the direct form
    task automatic sc_no_disp();
        logic [15:0] ea [8] = '{16'h1300, 16'h1040, 16'h2300, 16'h2040,
                                16'h0300, 16'h0040, 16'h0000, 16'h1000};
        logic [1:0] sg [8] = '{2'b11, 2'b11, 2'b10, 2'b10, 2'b11, 2'b11, 2'b11, 2'b11};
        for (int s = 0; s < 8; s++) begin
            if (s != 6) begin
                op({5'b00000, s[2:0]}, 8'h00, 8'h00, 0);
                `CHK(result_q.effective_address, ea[s])
                `CHK(result_q.segment, sg[s])
                `CHK(ea_cycles_q, 8'h04)
                `CHK(op_known_q, 1'b0)
            end
        end
    endtask

    // Displacement forms; the negative byte checks sign extension
    task automatic sc_disp();
        op(8'h86, 8'h34, 8'h12, 2);
        `CHK(result_q.effective_address, 16'h3234)
        `CHK(result_q.segment, 2'b10)
        op(8'h40, 8'h80, 8'h00, 1);
        `CHK(result_q.effective_address, 16'h1280)
        op(8'h06, 8'h78, 8'h56, 2);
        `CHK(result_q.effective_address, 16'h5678)
    endtask

    // Register form in byte and word width
    task automatic sc_register();
        @(posedge clk);
        word_op <= 1'b0;
        op(8'hC5, 8'h00, 8'h00, 0);
        `CHK({result_q.is_reg, result_q.reg_num}, 5'h15)
        `CHK(ea_cycles_q, 8'h00)
        @(posedge clk);
        word_op <= 1'b1;
        op(8'hC3, 8'h00, 8'h00, 0);
        `CHK({result_q.is_reg, result_q.reg_num}, 5'h1B)
    endtask

    // All four override codes, then a string destination that ignores one
    task automatic sc_override();
        for (int c = 0; c < 4; c++) begin
            oad_core_model_inst.send({3'b001, c[1:0], 3'b110}, 1'b1);
            #1;
            `CHK(prefix_q, 1'b1)
            op(8'h46, 8'h10, 8'h00, 1);
            `CHK(result_q.segment, c[1:0])
        end
        @(posedge clk);
        string_dst <= 1'b1;
        oad_core_model_inst.send(8'h3E, 1'b1);
        op(8'h05, 8'h00, 8'h00, 0);
        `CHK(result_q.segment, 2'b00)
        @(posedge clk);
        string_dst <= 1'b0;
    endtask

    // Cycle counts for the timed opcodes other than bus-hold, both outcomes and word transfers
    task automatic sc_cycles();
        oad_cyc_case_type t [11] = '{
            '{8'hE1, 1'b0, 8'h00, 1'b0, 2'b00, 8'h06}, '{8'hE1, 1'b1, 8'h00, 1'b0, 2'b00, 8'h10},
            '{8'hE0, 1'b1, 8'h00, 1'b0, 2'b00, 8'h10}, '{8'hE0, 1'b0, 8'h00, 1'b0, 2'b00, 8'h06},
            '{8'hC8, 1'b0, 8'h00, 1'b0, 2'b00, 8'h13}, '{8'hC8, 1'b0, 8'h01, 1'b0, 2'b00, 8'h1D},
            '{8'hC8, 1'b0, 8'h03, 1'b0, 2'b00, 8'h42}, '{8'hCE, 1'b1, 8'h00, 1'b0, 2'b00, 8'h30},
            '{8'hCE, 1'b0, 8'h00, 1'b0, 2'b00, 8'h04}, '{8'h62, 1'b0, 8'h00, 1'b0, 2'b00, 8'h23},
            '{8'h62, 1'b0, 8'h00, 1'b1, 2'b10, 8'h2B}};
        for (int k = 0; k < 11; k++) begin
            @(posedge clk);
            taken <= t[k].tk;
            level <= t[k].lv;
            word_op <= t[k].wd;
            mem_xfers <= t[k].nx;
            oad_core_model_inst.send(t[k].opc, 1'b1);
            oad_core_model_inst.send(8'hC0, 1'b0);
            wait_res();
            `CHK(op_cycles_q, t[k].cyc)
            `CHK(op_known_q, 1'b1)
        end
    endtask

    // Bus-hold prefix pulses and reports its own count
    task automatic sc_bushold();
        @(posedge clk);
        word_op <= 1'b0;
        oad_core_model_inst.send(8'hF0, 1'b1);
        #1;
        `CHK({prefix_q, bushold_q}, 2'b11)
        @(posedge clk);
        #1;
        `CHK(op_cycles_q, 8'h02)
    endtask

    // Main sequence: reset for four cycles, then the scenarios
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        sc_no_disp();
        sc_disp();
        sc_register();
        sc_override();
        sc_cycles();
        sc_bushold();
        conclude();
    end
endmodule // testbench
`default_nettype wire
